// [core/emhk_pkg.sv]
// Shared constants, types and helpers for the external memory high-mask and keeper block
`default_nettype none
package emhk_pkg;
  // Register offsets (byte addresses)
  localparam logic [11:0] SFIO_OFF = 12'h000;
  localparam logic [11:0] CTRL_OFF = 12'h004;
  localparam logic [11:0] PDIR_OFF = 12'h008;
  localparam logic [11:0] POUT_OFF = 12'h00c;
  localparam logic [11:0] STAT_OFF = 12'h010;
  // Field positions
  localparam int KEEP_BIT = 6;
  localparam int MASK_LSB = 3;
  localparam int MASK_MSB = 5;
  localparam int EME_BIT = 0;
  localparam int STAT_REL_LSB = 0;
  localparam int STAT_KVAL_LSB = 8;
  localparam int STAT_KACT_BIT = 16;
  localparam int STAT_BUSY_BIT = 17;
  localparam logic [7:0] SFIO_WMASK = 8'h78;
  // Reset values
  localparam logic [7:0] SFIO_RST = 8'h00;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [7:0] PDIR_RST = 8'h00;
  localparam logic [7:0] POUT_RST = 8'h00;
  // Address map
  localparam logic [15:0] INT_TOP = 16'h025f;
  localparam logic [16:0] EXT_BYTES = 17'h0fda0;
  localparam logic [2:0] MASK_ALL = 3'h7;
  // Timing counts
  localparam int STROBE_CYCLES_DEF = 1;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_END} emhk_state_e;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } emhk_mreq_s;

  typedef struct packed {
    logic internal;
    logic [7:0] rdata;
  } emhk_mrsp_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } emhk_pins_s;

  // High-port pins given back to port use, top pin first
  function automatic logic [7:0] released_pins(input logic [2:0] m);
    released_pins = (m == MASK_ALL) ? 8'hff : ~(8'hff >> m);
  endfunction

  // Address lies beyond the internal region
  function automatic logic is_external(input logic [15:0] a);
    is_external = (a > INT_TOP);
  endfunction
endpackage
`default_nettype wire

// [core/emhk_high_port.sv]
// High-address port pin multiplexer with registered pin outputs
`default_nettype none
module emhk_high_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic ext_en,
  input wire logic [2:0] mask,
  // Sources
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] port_dir,
  input wire logic [7:0] port_out,
  // Pins
  output var emhk_pkg::emhk_pins_s pins
);
  import emhk_pkg::*;

  typedef struct packed {
    emhk_pins_s pins;
  } emhk_hp_state_s;

  emhk_hp_state_s s_reg;
  emhk_hp_state_s s_next;
  logic [7:0] rel;

  always_comb begin
    rel = ext_en ? released_pins(mask) : 8'hff; // RULE_05
    s_next = s_reg;
    for (int i = 0; i < 8; i++) begin
      if (rel[i]) begin
        s_next.pins.out[i] = port_out[i]; // RULE_06 RULE_10
        s_next.pins.oe_n[i] = ~port_dir[i]; // RULE_11
      end else begin
        s_next.pins.out[i] = addr_hi[i]; // RULE_04
        s_next.pins.oe_n[i] = 1'b0; // RULE_11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{pins: '{out: 8'h00, oe_n: 8'hff}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins = s_reg.pins;

  AST_FULL_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    ext_en && mask == 3'h0 |=> pins.oe_n == 8'h00 && pins.out == $past(addr_hi))
    else $error("full high address byte not driven");
  AST_MASK_THREE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    ext_en && mask == 3'h3 |=> pins.oe_n[4:0] == 5'h00 && pins.out[4:0] == $past(addr_hi[4:0]))
    else $error("five address bits not driven for mask three");
  AST_PORT_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
    ext_en && mask == 3'h3 && port_out[7:5] == 3'h0 && port_dir[7:5] == 3'h7
    |=> pins.out[7:5] == 3'h0 && pins.oe_n[7:5] == 3'h0)
    else $error("released top pins do not show port zero");
  AST_ALL_RELEASED: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    ext_en && mask == MASK_ALL |=> pins.out == $past(port_out) && pins.oe_n == ~$past(port_dir))
    else $error("fully released port not under port control");
  AST_DISABLED_PORT: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    !ext_en |=> pins.out == $past(port_out) && pins.oe_n == ~$past(port_dir))
    else $error("port not restored when interface disabled");
endmodule
`default_nettype wire

// [core/emhk_keeper.sv]
// Bus keeper for the multiplexed address/data lines
`default_nettype none
module emhk_keeper (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic keep_en,
  // Line observation
  input wire logic drive_oe_n,
  input wire logic [7:0] drive_val,
  input wire logic ext_drive,
  input wire logic [7:0] line_in,
  // Keeper drive
  output logic keep_active,
  output logic [7:0] keep_val
);
  import emhk_pkg::*;

  typedef struct packed {
    logic active;
    logic [7:0] val;
  } emhk_kp_state_s;

  emhk_kp_state_s s_reg;
  emhk_kp_state_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.active = keep_en; // RULE_03
    if (!drive_oe_n) begin
      s_next.val = drive_val; // RULE_02
    end else if (ext_drive) begin
      s_next.val = line_in; // RULE_02
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{active: 1'b0, val: 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  assign keep_active = s_reg.active;
  assign keep_val = s_reg.val;

  AST_KEEP_LAST: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    !drive_oe_n |=> keep_val == $past(drive_val))
    else $error("keeper lost last driven value");
  AST_KEEP_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    drive_oe_n && !ext_drive |=> $stable(keep_val))
    else $error("keeper value moved while lines released");
endmodule
`default_nettype wire

// [core/emhk_top.sv]
// External memory interface: high-address masking, bus keeper and APB registers
// Contract
// RULE_01: Keeper-enable bit switches bus keeper on/off.
// RULE_02: Active keeper holds last driven line value.
// RULE_03: Keeper ignores the interface-enable bit.
// RULE_04: Mask zero drives all eight high pins.
// RULE_05: Mask value releases top pins, seven releases all.
// RULE_06: Released pins follow port direction and output.
// RULE_07: Internal-range addresses start no external cycle.
// RULE_08: Data-space address driven unmodified onto pins.
// RULE_09: External space is addresses above internal region.
// RULE_10: Released pins set zero confine address range.
// RULE_11: Interface enable takes pins, clearing restores ports.
// RULE_12: Mask change applies from the next access.
//
// Our own choices: the placing of the registers and register access over APB.
`default_nettype none
module emhk_top #(
  parameter int STROBE_CYCLES = emhk_pkg::STROBE_CYCLES_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core data-space access
  input wire logic mreq_valid,
  input wire emhk_pkg::emhk_mreq_s mreq,
  output logic mreq_ready,
  output logic mrsp_valid,
  output var emhk_pkg::emhk_mrsp_s mrsp,
  // Multiplexed address/data lines
  input wire logic [7:0] mux_addr_data_in,
  output logic [7:0] mux_addr_data_out,
  output logic mux_addr_data_oe_n,
  output logic keeper_active,
  output logic [7:0] keeper_value,
  // Strobes
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  // High-address port
  output var emhk_pkg::emhk_pins_s high_port
);
  import emhk_pkg::*;

  if (STROBE_CYCLES < 1 || STROBE_CYCLES > 4) begin : g_strobe_check
    $error("STROBE_CYCLES must lie in 1..4");
  end

  localparam logic [1:0] STROBE_LAST = 2'(STROBE_CYCLES - 1);
  localparam int EXT_LAT = STROBE_CYCLES + 2;

  typedef struct packed {
    emhk_state_e st;
    logic [1:0] cnt;
    emhk_mreq_s req;
    logic [2:0] cyc_mask;
    logic cyc_en;
    logic [7:0] special_function_io;
    logic ctrl_en;
    logic [7:0] pdir;
    logic [7:0] pout;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mreq_ready;
    logic mrsp_valid;
    emhk_mrsp_s mrsp;
    logic [7:0] ad_out;
    logic ad_oe_n;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [7:0] hi_addr;
  } emhk_top_state_s;

  emhk_top_state_s s_reg;
  emhk_top_state_s s_next;
  logic take;
  logic apb_wr;
  logic kp_active;
  logic [7:0] kp_val;

  assign take = mreq_valid && s_reg.mreq_ready;
  assign apb_wr = psel && penable && s_reg.pready && pwrite && !s_reg.pslverr && pstrb[0];

  always_comb begin
    s_next = s_reg;
    // Register bus: answer prepared in setup, write at access edge
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    if (psel && !penable) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      unique case (paddr)
        SFIO_OFF: s_next.prdata[7:0] = s_reg.special_function_io;
        CTRL_OFF: s_next.prdata[EME_BIT] = s_reg.ctrl_en;
        PDIR_OFF: s_next.prdata[7:0] = s_reg.pdir;
        POUT_OFF: s_next.prdata[7:0] = s_reg.pout;
        STAT_OFF: begin
          s_next.prdata[STAT_REL_LSB +: 8] = s_reg.cyc_en ? released_pins(s_reg.cyc_mask) : 8'hff;
          s_next.prdata[STAT_KVAL_LSB +: 8] = kp_val;
          s_next.prdata[STAT_KACT_BIT] = kp_active;
          s_next.prdata[STAT_BUSY_BIT] = (s_reg.st != ST_IDLE);
        end
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (apb_wr) begin
      unique case (paddr)
        SFIO_OFF: s_next.special_function_io = pwdata[7:0] & SFIO_WMASK; // RULE_01
        CTRL_OFF: s_next.ctrl_en = pwdata[EME_BIT]; // RULE_11
        PDIR_OFF: s_next.pdir = pwdata[7:0];
        POUT_OFF: s_next.pout = pwdata[7:0];
        default: s_next.pout = s_reg.pout;
      endcase
    end
    // External cycle sequencer
    s_next.mrsp_valid = 1'b0;
    unique case (s_reg.st)
      ST_IDLE: begin
        s_next.ad_oe_n = 1'b1;
        s_next.cyc_mask = s_reg.special_function_io[MASK_MSB:MASK_LSB]; // RULE_12
        s_next.cyc_en = s_reg.ctrl_en; // RULE_11
        if (take) begin
          s_next.req = mreq;
          if (!is_external(mreq.addr) || !s_reg.ctrl_en) begin
            s_next.mrsp_valid = 1'b1; // RULE_07
            s_next.mrsp = '{internal: 1'b1, rdata: 8'h00};
          end else begin
            s_next.st = ST_ADDR; // RULE_09
            s_next.mreq_ready = 1'b0;
            s_next.ale = 1'b1;
            s_next.ad_out = mreq.addr[7:0]; // RULE_08
            s_next.hi_addr = mreq.addr[15:8]; // RULE_08
            s_next.ad_oe_n = 1'b0;
          end
        end
      end
      ST_ADDR: begin
        s_next.ale = 1'b0;
        s_next.cnt = STROBE_LAST;
        s_next.st = ST_STROBE;
        if (s_reg.req.write) begin
          s_next.wr_n = 1'b0;
          s_next.ad_out = s_reg.req.wdata;
        end else begin
          s_next.rd_n = 1'b0;
          s_next.ad_oe_n = 1'b1;
        end
      end
      ST_STROBE: begin
        if (s_reg.cnt == 2'h0) begin
          if (!s_reg.req.write) begin
            s_next.mrsp.rdata = mux_addr_data_in;
          end else begin
            s_next.mrsp.rdata = 8'h00;
          end
          s_next.mrsp.internal = 1'b0;
          s_next.rd_n = 1'b1;
          s_next.wr_n = 1'b1;
          s_next.st = ST_END;
        end else begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end
      end
      ST_END: begin
        s_next.ad_oe_n = 1'b1;
        s_next.mrsp_valid = 1'b1;
        s_next.mreq_ready = 1'b1;
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{
        st: ST_IDLE,
        cnt: 2'h0,
        req: '{write: 1'b0, addr: 16'h0000, wdata: 8'h00},
        cyc_mask: 3'h0,
        cyc_en: CTRL_RST,
        special_function_io: SFIO_RST,
        ctrl_en: CTRL_RST,
        pdir: PDIR_RST,
        pout: POUT_RST,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0,
        mreq_ready: 1'b1,
        mrsp_valid: 1'b0,
        mrsp: '{internal: 1'b0, rdata: 8'h00},
        ad_out: 8'h00,
        ad_oe_n: 1'b1,
        ale: 1'b0,
        rd_n: 1'b1,
        wr_n: 1'b1,
        hi_addr: 8'h00
      };
    end else begin
      s_reg <= s_next;
    end
  end

  emhk_high_port i_emhk_high_port (
    .pclk(pclk),
    .presetn(presetn),
    .ext_en(s_next.cyc_en),
    .mask(s_next.cyc_mask),
    .addr_hi(s_next.hi_addr),
    .port_dir(s_next.pdir),
    .port_out(s_next.pout),
    .pins(high_port)
  );

  emhk_keeper i_emhk_keeper (
    .pclk(pclk),
    .presetn(presetn),
    .keep_en(s_next.special_function_io[KEEP_BIT]),
    .drive_oe_n(s_next.ad_oe_n),
    .drive_val(s_next.ad_out),
    .ext_drive(s_reg.st == ST_STROBE && !s_reg.req.write),
    .line_in(mux_addr_data_in),
    .keep_active(kp_active),
    .keep_val(kp_val)
  );

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign mreq_ready = s_reg.mreq_ready;
  assign mrsp_valid = s_reg.mrsp_valid;
  assign mrsp = s_reg.mrsp;
  assign mux_addr_data_out = s_reg.ad_out;
  assign mux_addr_data_oe_n = s_reg.ad_oe_n;
  assign keeper_active = kp_active;
  assign keeper_value = kp_val;
  assign ale = s_reg.ale;
  assign rd_n = s_reg.rd_n;
  assign wr_n = s_reg.wr_n;

  AST_KEEP_ON: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    $rose(s_reg.special_function_io[KEEP_BIT]) |-> keeper_active)
    else $error("keeper not active after enable");
  AST_KEEP_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    $fell(s_reg.special_function_io[KEEP_BIT]) |-> !keeper_active)
    else $error("keeper still active after disable");
  AST_KEEP_NO_SRE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    !s_reg.ctrl_en && s_reg.special_function_io[KEEP_BIT] |-> keeper_active)
    else $error("keeper dropped while interface disabled");
  AST_INTERNAL_SKIP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    take && !is_external(mreq.addr) |=> mrsp_valid && mrsp.internal && !ale ##1 !ale)
    else $error("internal address started an external cycle");
  AST_ADDR_OUT: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    $rose(ale) |-> mux_addr_data_out == s_reg.req.addr[7:0] && !mux_addr_data_oe_n
    ##1 (s_reg.cyc_mask == MASK_ALL
    || ((high_port.out ^ s_reg.req.addr[15:8]) << s_reg.cyc_mask) == 8'h00))
    else $error("address not driven unmodified");
  AST_EXT_START: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    take && mreq.addr > INT_TOP && s_reg.ctrl_en |=> ale ##EXT_LAT mrsp_valid && !mrsp.internal)
    else $error("external cycle missing or too long");
  AST_EXT_SIZE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    $rose(ale) |-> 17'(s_reg.req.addr) >= 17'h10000 - EXT_BYTES)
    else $error("external cycle below external space");
  AST_MASK_FROZEN: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    s_reg.st != ST_IDLE && s_next.st != ST_IDLE |=> $stable(s_reg.cyc_mask))
    else $error("mask changed inside an external cycle");
  AST_DISABLED_PINS: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    s_reg.st == ST_IDLE && !s_reg.ctrl_en |=> mux_addr_data_oe_n && rd_n && wr_n)
    else $error("interface drives pins while disabled");

  // Register checks
  AST_KEEP_STORE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    apb_wr && paddr == SFIO_OFF
    |=> s_reg.special_function_io[KEEP_BIT] == $past(pwdata[KEEP_BIT]))
    else $error("keeper enable not stored");
  AST_MASK_STORE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    apb_wr && paddr == SFIO_OFF
    |=> s_reg.special_function_io[MASK_MSB:MASK_LSB] == $past(pwdata[MASK_MSB:MASK_LSB]))
    else $error("mask field not stored");
  AST_EN_STORE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    apb_wr && paddr == CTRL_OFF |=> s_reg.ctrl_en == $past(pwdata[EME_BIT]))
    else $error("interface enable not stored");

  // Keeper checks
  AST_KEEP_DRIVEN: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    !mux_addr_data_oe_n |-> keeper_value == mux_addr_data_out)
    else $error("keeper does not follow driven value");
  AST_KEEP_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    keeper_active == s_reg.special_function_io[KEEP_BIT])
    else $error("keeper activity differs from enable bit");
  AST_WRITE_DATA: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    !wr_n |-> !mux_addr_data_oe_n && mux_addr_data_out == s_reg.req.wdata)
    else $error("write data not driven during strobe");
  AST_READ_RELEASE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    !rd_n |-> mux_addr_data_oe_n)
    else $error("lines driven during read strobe");
  AST_READ_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    $rose(rd_n) |-> keeper_value == $past(mux_addr_data_in))
    else $error("keeper missed read data");

  // Pin checks
  AST_HIGH_FULL_CYCLE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    s_reg.st != ST_IDLE && s_reg.cyc_mask == 3'h0
    |-> high_port.oe_n == 8'h00 && high_port.out == s_reg.req.addr[15:8])
    else $error("high byte not driven in full");
  AST_HIGH_MASKED: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    s_reg.st != ST_IDLE && s_reg.cyc_mask != MASK_ALL
    |-> ((high_port.out ^ s_reg.req.addr[15:8]) << s_reg.cyc_mask) == 8'h00)
    else $error("unmasked high bits wrong");
  AST_TOP_PIN_PORT: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    s_reg.st != ST_IDLE && s_reg.cyc_mask != 3'h0
    |-> high_port.out[7] == s_reg.pout[7] && high_port.oe_n[7] == !s_reg.pdir[7])
    else $error("released top pin not under port control");
  AST_HIGH_ADDR: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    $rose(ale) |-> s_reg.hi_addr == s_reg.req.addr[15:8])
    else $error("high address byte altered");

  // Sequencer checks
  AST_DISABLED_SKIP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    take && !s_reg.ctrl_en |=> mrsp_valid && mrsp.internal && !ale)
    else $error("disabled interface started a cycle");
  AST_ALE_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    ale |=> !ale)
    else $error("latch enable longer than one cycle");
  AST_MASK_LATCH: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    s_reg.st == ST_IDLE
    |=> s_reg.cyc_mask == $past(s_reg.special_function_io[MASK_MSB:MASK_LSB]))
    else $error("idle mask not latched");
  AST_EXT_ABOVE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    mrsp_valid && !mrsp.internal |-> s_reg.req.addr > INT_TOP)
    else $error("external answer for internal address");

  COV_READ: cover property (@(posedge pclk) disable iff (!presetn)
    !rd_n ##[1:4] mrsp_valid);
  COV_WRITE: cover property (@(posedge pclk) disable iff (!presetn)
    !wr_n ##[1:4] mrsp_valid);
  COV_INTERNAL: cover property (@(posedge pclk) disable iff (!presetn)
    mrsp_valid && mrsp.internal);
  COV_MASK_MID: cover property (@(posedge pclk) disable iff (!presetn)
    s_reg.st != ST_IDLE && apb_wr && paddr == SFIO_OFF);
  COV_KEEP_IDLE: cover property (@(posedge pclk) disable iff (!presetn)
    !s_reg.ctrl_en && keeper_active);
endmodule
`default_nettype wire

// [dv/emhk_sram_model.sv]
// Behavioural asynchronous SRAM on the multiplexed address/data bus
`default_nettype none
module emhk_sram_model (
  // Strobes
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  // Address and data
  input wire logic [7:0] ad,
  input wire logic [7:0] addr_hi,
  output logic dq_drive,
  output logic [7:0] dq,
  output logic [15:0] last_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] lo;
  // Low byte taken while the latch enable is high
  always @(posedge ale) #10 lo = ad;
  // Full address taken early in the strobe
  always @(negedge rd_n or negedge wr_n) #10 last_addr = {addr_hi, lo};
  always @(posedge wr_n) mem[last_addr] = ad;
  assign dq_drive = !rd_n;
  // Released bus shows the inverse of the stored byte
  assign dq = rd_n ? ~mem[last_addr] : mem[last_addr];
endmodule
`default_nettype wire

// [dv/ext_mem_high_mask_keeper_bench.sv]
// Self-checking bench for the high-mask and keeper block
`default_nettype none
module ext_mem_high_mask_keeper_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import emhk_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mreq_valid = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rd2;
  logic [3:0] pstrb = 4'h1;
  logic pready, pslverr, mreq_ready, mrsp_valid, ad_oe_n, keeper_active, ale, rd_n, wr_n;
  logic err, err2, sram_drive;
  emhk_mreq_s mreq = '0;
  emhk_mrsp_s mrsp;
  emhk_pins_s high_port;
  logic [7:0] ad_out, keeper_value, ad_wire, sram_dq;
  logic [15:0] sram_addr;
  int n_mismatch = 0, samples_checked = 0, n_ale = 0, cyc = 0;

  // Wire level: design, then SRAM, then keeper, else a toggling pattern
  assign ad_wire = !ad_oe_n ? ad_out : sram_drive ? sram_dq :
                   keeper_active ? keeper_value : (8'h96 ^ {8{pclk}});

  emhk_top #(.STROBE_CYCLES(1)) i_emhk_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mreq_valid(mreq_valid),
    .mreq(mreq), .mreq_ready(mreq_ready), .mrsp_valid(mrsp_valid), .mrsp(mrsp),
    .mux_addr_data_in(ad_wire), .mux_addr_data_out(ad_out), .mux_addr_data_oe_n(ad_oe_n),
    .keeper_active(keeper_active), .keeper_value(keeper_value), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .high_port(high_port));

  emhk_sram_model i_emhk_sram_model (.ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad(ad_wire),
    .addr_hi(high_port.out), .dq_drive(sram_drive), .dq(sram_dq), .last_addr(sram_addr));

  initial begin
    forever #50 pclk = ~pclk;
  end

  always @(posedge ale) n_ale++;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic macc(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic i);
    @(posedge pclk);
    mreq_valid <= 1'b1;
    mreq <= '{write: w, addr: a, wdata: d};
    do @(posedge pclk); while (mreq_ready !== 1'b1);
    mreq_valid <= 1'b0;
    do @(posedge pclk); while (mrsp_valid !== 1'b1);
    r = {24'h0, mrsp.rdata};
    i = mrsp.internal;
  endtask

  task automatic t_regs();
    apb(1'b0, SFIO_OFF, 32'h0, rd, err);
    chk(rd, 32'h0);
    apb(1'b1, SFIO_OFF, 32'hff, rd, err);
    apb(1'b0, SFIO_OFF, 32'h0, rd, err);
    chk(rd, 32'h78);
    chk(32'(keeper_active), 32'h1);
    apb(1'b1, SFIO_OFF, 32'h0, rd, err);
    @(posedge pclk);
    chk(32'(keeper_active), 32'h0);
    apb(1'b0, 12'h020, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    $display("t_regs done");
  endtask

  task automatic t_disabled();
    int na;
    apb(1'b1, PDIR_OFF, 32'h5a, rd, err);
    apb(1'b1, POUT_OFF, 32'h3c, rd, err);
    repeat (2) @(posedge pclk);
    chk(32'(high_port.oe_n), 32'ha5);
    chk(32'(high_port.out), 32'h3c);
    na = n_ale;
    macc(1'b1, 16'h1000, 8'h11, rd, err);
    chk({rd[30:0], err}, 32'h1);
    chk(32'(n_ale), 32'(na));
    $display("t_disabled done");
  endtask

  task automatic t_ext();
    int na;
    apb(1'b1, CTRL_OFF, 32'h1, rd, err);
    apb(1'b1, SFIO_OFF, 32'h40, rd, err);
    macc(1'b1, 16'h1234, 8'ha5, rd, err);
    chk(32'(i_emhk_sram_model.mem[16'h1234]), 32'ha5);
    chk(32'(high_port.oe_n), 32'h0);
    macc(1'b0, 16'h1234, 8'h00, rd, err);
    chk({rd[30:0], err}, 32'h14a);
    repeat (2) @(posedge pclk);
    chk({23'h0, keeper_active, keeper_value}, 32'h1a5);
    apb(1'b0, STAT_OFF, 32'h0, rd, err);
    chk(rd, 32'h0001_a500);
    na = n_ale;
    macc(1'b1, 16'h025f, 8'h77, rd, err);
    chk({rd[30:0], err}, 32'h1);
    chk(32'(n_ale), 32'(na));
    macc(1'b1, 16'h0260, 8'h66, rd, err);
    chk({15'h0, sram_addr, err}, 32'h4c0);
    macc(1'b1, 16'h8001, 8'h55, rd, err);
    chk(32'(sram_addr), 32'h8001);
    $display("t_ext done");
  endtask

  task automatic t_mask();
    apb(1'b1, PDIR_OFF, 32'hff, rd, err);
    apb(1'b1, POUT_OFF, 32'h0, rd, err);
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, SFIO_OFF, 32'(m << 3), rd, err);
      macc(1'b1, 16'hffff, 8'(m), rd, err);
      chk(32'(sram_addr), (m == 7) ? 32'h00ff : (32'hffff >> m));
    end
    $display("t_mask done");
  endtask

  task automatic t_mask_mid();
    apb(1'b1, SFIO_OFF, 32'h0, rd, err);
    fork
      macc(1'b1, 16'hffff, 8'h01, rd, err);
      apb(1'b1, SFIO_OFF, 32'h38, rd2, err2);
    join
    chk(32'(sram_addr), 32'hffff);
    macc(1'b1, 16'hffff, 8'h02, rd, err);
    chk(32'(sram_addr), 32'h00ff);
    $display("t_mask_mid done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_disabled();
    t_ext();
    t_mask();
    t_mask_mid();
    report_and_stop();
  end
endmodule
`default_nettype wire
